// ---- design/sdis_defs.svh ----
`ifndef SDIS_DEFS_SVH
`define SDIS_DEFS_SVH
// Register byte offsets
`define SDIS_OFF_SUMMARY 8'h00
`define SDIS_OFF_SSTAT_LO 8'h04
`define SDIS_OFF_SSTAT_HI 8'h08
`define SDIS_OFF_DMA_IRQ_STATUS 8'h0C
`define SDIS_OFF_SEN_LO 8'h10
`define SDIS_OFF_SEN_HI 8'h14
`define SDIS_OFF_DEN 8'h18
`define SDIS_OFF_CTRL 8'h1C
`define SDIS_OFF_MODE 8'h20
// Field positions
`define SDIS_SUM_DIP 0
`define SDIS_SUM_SIP 1
`define SDIS_SUM_FLY 2
`define SDIS_CTRL_PINMASK 1
`define SDIS_MODE_TARGET 0
`define SDIS_DMA_IRQ_STATUS_FIFO_EMPTY 7
// Condition classes, SCSI status bits 15..0
`define SDIS_NONFATAL_INIT 16'h0370
`define SDIS_NONFATAL_TGT 16'h03F0
// Reset values
`define SDIS_RST_SEN 16'h0000
`define SDIS_RST_DEN 7'h00
`define SDIS_RST_CTRL 1'b0
`define SDIS_RST_MODE 1'b0
// Timing: least pin-off gap before stacked conditions move in
`define SDIS_GAP_CYCLES 2'h3
`endif

// ---- design/sdis_pkg.sv ----
package sdis_pkg;
   localparam int SDIS_SW = 16;
   localparam int SDIS_DW = 7;

   typedef enum logic [1:0] {SDIS_RUN, SDIS_SETTLE, SDIS_HALTED} sdis_halt_st_t;

   typedef enum logic [3:0] {SDIS_R_NONE, SDIS_R_SUM, SDIS_R_SLO, SDIS_R_SHI, SDIS_R_DST,
                             SDIS_R_ELO, SDIS_R_EHI, SDIS_R_DEN, SDIS_R_CTRL, SDIS_R_MODE} sdis_reg_t;

   typedef struct packed {
      logic fetch_busy;
      logic bus_fault;
      logic dma_to_mem;
      logic cycle_busy;
      logic hs_busy;
      logic offset_busy;
      logic xfer_ctl_busy;
      logic phase_jump;
      logic resume;
   } sdis_eng_in_t;

   typedef struct packed {
      logic stop_req;
      logic drain_req;
      logic halted;
      logic load_target;
   } sdis_eng_out_t;
endpackage

// ---- design/sdis_stack_cell.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdis_stack_cell #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [W-1:0] arrive,
   input wire logic stack_en,
   input wire logic [W-1:0] clr,
   input wire logic promote,
   output logic [W-1:0] level1,
   output logic [W-1:0] level2
);
   logic [W-1:0] l1_r;
   logic [W-1:0] l2_r;
   logic [W-1:0] l1_nxt;
   logic [W-1:0] l2_nxt;

   // Arrivals always win over a clear in the same cycle
   assign l1_nxt = promote ? ((l1_r & ~clr) | l2_r | arrive) : ((l1_r & ~clr) | (stack_en ? '0 : arrive));
   assign l2_nxt = promote ? '0 : (l2_r | (stack_en ? arrive : '0));
   assign level1 = l1_r;
   assign level2 = l2_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         l1_r <= '0;
         l2_r <= '0;
      end
      else if (ce)
      begin
         l1_r <= l1_nxt;
         l2_r <= l2_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- design/sdis_halt_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdis_halt_seq
   import sdis_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic fatal_scsi,
   input wire logic fatal_dma,
   input wire logic fifo_empty,
   input wire sdis_eng_in_t eng,
   output sdis_eng_out_t eng_out
);
   sdis_halt_st_t st_r;
   sdis_eng_out_t out_r;
   logic drain_r;
   wire fetch_ok = !eng.fetch_busy || eng.bus_fault;
   wire data_ok = drain_r ? fifo_empty : !eng.cycle_busy;
   wire link_ok = !eng.hs_busy && !eng.offset_busy;
   wire quiet = fetch_ok && data_ok && link_ok && !eng.xfer_ctl_busy;

   assign eng_out = out_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_r <= SDIS_RUN;
         out_r <= '0;
         drain_r <= 1'b0;
      end
      else if (ce)
      begin
         out_r.load_target <= 1'b0;
         case (st_r)
            SDIS_RUN:
            begin
               if (fatal_scsi || fatal_dma)
               begin
                  st_r <= SDIS_SETTLE;
                  out_r.stop_req <= 1'b1;
                  // DMA conditions never flush; only SCSI on memory writes
                  drain_r <= fatal_scsi && eng.dma_to_mem;
                  out_r.drain_req <= fatal_scsi && eng.dma_to_mem;
               end
            end
            SDIS_SETTLE:
            begin
               if (quiet)
               begin
                  st_r <= SDIS_HALTED;
                  out_r.halted <= 1'b1;
                  out_r.drain_req <= 1'b0;
                  out_r.load_target <= eng.phase_jump;
               end
            end
            SDIS_HALTED:
            begin
               if (eng.resume)
               begin
                  st_r <= SDIS_RUN;
                  out_r <= '0;
                  drain_r <= 1'b0;
               end
            end
            default:
            begin
               st_r <= SDIS_RUN;
               out_r <= '0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- design/sdis_irq_stack.sv ----
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sdis_defs.svh"
// Notes on behaviour
// - A cleared enable bit masks that SCSI or DMA source from the request pin.
// - Masked non-fatal condition: status bit set, engine runs, no pending bit, no pin.
// - Masked fatal condition: engine halts, status and pending bits set, pin stays off.
// - While a pending bit is set, new conditions go to hidden second-level registers.
// - With both levels full, further conditions are ORed into the second level.
// - Clearing the first level moves all second-level conditions into visible status.
// - After a clearing read the pin stays off three cycles, then stacked ones reassert.
// - Masked non-fatal conditions do not start stacking and stay set later.
// - Conditions arriving before a pending bit sets all land in the first level.
// - DMA-type conditions never flush the FIFOs before halting.
// - New SCSI conditions are held back while the DMA FIFO has data.
// - A started fetch finishes unless bus fault; the fetched instruction is not run.
// - SCSI condition during DMA write drains the FIFO; otherwise only current cycle.
// - A begun handshake and outstanding synchronous offset finish before halting.
// - Transfer-control instructions complete; phase jump loads its target first.
// - The on-the-fly bit clears only by writing one; host clears it first.
// - Reading SCSI or DMA status clears and returns the reported conditions.
// - Pin-mask bit holds the pin off without loss; clearing it asserts at once.
// - Only the listed timer, completion and selection events are non-fatal; DMA is fatal.
// - DMA FIFO-empty status bit never interrupts and is not cleared by reads.
module sdis_irq_stack
   import sdis_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [SDIS_SW-1:0] scsi_evt,
   input wire logic [SDIS_DW-1:0] dma_evt,
   input wire logic fly_evt,
   input wire logic dma_fifo_empty,
   input wire sdis_eng_in_t eng_in,
   output sdis_eng_out_t eng_out,
   output logic irq_req_n
);
   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   function automatic sdis_reg_t sdis_reg_sel(input logic [7:0] a);
      sdis_reg_t r;
      r = SDIS_R_NONE;
      case ({a[7:2], 2'b00})
         `SDIS_OFF_SUMMARY: r = SDIS_R_SUM;
         `SDIS_OFF_SSTAT_LO: r = SDIS_R_SLO;
         `SDIS_OFF_SSTAT_HI: r = SDIS_R_SHI;
         `SDIS_OFF_DMA_IRQ_STATUS: r = SDIS_R_DST;
         `SDIS_OFF_SEN_LO: r = SDIS_R_ELO;
         `SDIS_OFF_SEN_HI: r = SDIS_R_EHI;
         `SDIS_OFF_DEN: r = SDIS_R_DEN;
         `SDIS_OFF_CTRL: r = SDIS_R_CTRL;
         `SDIS_OFF_MODE: r = SDIS_R_MODE;
         default: r = SDIS_R_NONE;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [SDIS_SW-1:0] s_en_r;
   logic [SDIS_DW-1:0] d_en_r;
   logic pin_mask_r;
   logic target_r;
   logic fly_r;
   logic [SDIS_SW-1:0] s_hold_r;
   logic [1:0] gap_r;
   logic irq_latched_r;
   logic irq_req_n_r;
   logic wr_pend_r;
   sdis_reg_t wr_sel_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;

   logic [SDIS_SW-1:0] s_l1;
   logic [SDIS_SW-1:0] s_l2;
   logic [SDIS_DW-1:0] d_l1;
   logic [SDIS_DW-1:0] d_l2;

   // ------------------------------------------------------------
   // Bus address phase
   // ------------------------------------------------------------
   wire addr_ok = hsel && htrans[1] && hready;
   wire rd_take = addr_ok && !hwrite;
   wire wr_take = addr_ok && hwrite;
   sdis_reg_t a_sel;
   assign a_sel = sdis_reg_sel(haddr[7:0]);

   // Reads clear in the address phase; the value returned is the one cleared
   wire rd_slo = rd_take && (a_sel == SDIS_R_SLO);
   wire rd_shi = rd_take && (a_sel == SDIS_R_SHI);
   wire rd_dst = rd_take && (a_sel == SDIS_R_DST);
   wire [SDIS_SW-1:0] s_clr = {{8{rd_shi}}, {8{rd_slo}}};
   wire [SDIS_DW-1:0] d_clr = {SDIS_DW{rd_dst}};

   wire wr_now = wr_pend_r;
   wire wr_sum = wr_now && (wr_sel_r == SDIS_R_SUM);
   wire wr_elo = wr_now && (wr_sel_r == SDIS_R_ELO);
   wire wr_ehi = wr_now && (wr_sel_r == SDIS_R_EHI);
   wire wr_den = wr_now && (wr_sel_r == SDIS_R_DEN);
   wire wr_ctl = wr_now && (wr_sel_r == SDIS_R_CTRL);
   wire wr_mod = wr_now && (wr_sel_r == SDIS_R_MODE);

   // ------------------------------------------------------------
   // Condition intake and classification
   // ------------------------------------------------------------
   // SCSI conditions locked out while the DMA FIFO still holds data
   wire [SDIS_SW-1:0] s_post = dma_fifo_empty ? (s_hold_r | scsi_evt) : '0;
   wire [SDIS_SW-1:0] s_hold_nxt = dma_fifo_empty ? '0 : (s_hold_r | scsi_evt);

   wire [SDIS_SW-1:0] s_nonfatal = target_r ? `SDIS_NONFATAL_TGT : `SDIS_NONFATAL_INIT;
   // Enabling a non-fatal source makes it fatal
   wire [SDIS_SW-1:0] s_sev = s_en_r | ~s_nonfatal;

   wire scsi_pend = |(s_l1 & s_sev);
   wire dma_pend = |d_l1;
   wire gap_busy = (gap_r != 2'h0);
   wire stack_en = scsi_pend || dma_pend || gap_busy;
   wire promote = (gap_r == 2'h1);

   wire fatal_scsi = |(s_post & s_sev);
   wire fatal_dma = |dma_evt;

   // ------------------------------------------------------------
   // Two-level stacks
   // ------------------------------------------------------------
   sdis_stack_cell #(
      .W(SDIS_SW)
   ) u_scsi_stack (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .arrive(s_post),
      .stack_en(stack_en),
      .clr(s_clr),
      .promote(promote),
      .level1(s_l1),
      .level2(s_l2)
   );

   sdis_stack_cell #(
      .W(SDIS_DW)
   ) u_dma_stack (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .arrive(dma_evt),
      .stack_en(stack_en),
      .clr(d_clr),
      .promote(promote),
      .level1(d_l1),
      .level2(d_l2)
   );

   // ------------------------------------------------------------
   // Orderly halt
   // ------------------------------------------------------------
   sdis_halt_seq u_halt (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .fatal_scsi(fatal_scsi),
      .fatal_dma(fatal_dma),
      .fifo_empty(dma_fifo_empty),
      .eng(eng_in),
      .eng_out(eng_out)
   );

   // ------------------------------------------------------------
   // Stack gap and request pin
   // ------------------------------------------------------------
   wire stacked = (|s_l2) || (|d_l2);
   wire any_clr = rd_slo || rd_shi || rd_dst;
   wire [1:0] gap_nxt = (any_clr && stacked) ? `SDIS_GAP_CYCLES : (gap_busy ? gap_r - 2'h1 : 2'h0);

   // Only enabled SCSI and DMA sources, and the on-the-fly bit, reach the pin
   wire pin_cond = (|(s_l1 & s_en_r)) || (|(d_l1 & d_en_r)) || fly_r;
   wire any_pend = scsi_pend || dma_pend || fly_r;
   // Once raised, later masking drops the request only if no summary bit stays set
   wire irq_latched_nxt = any_pend && (irq_latched_r || pin_cond);
   wire irq_on = irq_latched_nxt && !pin_mask_r && !gap_busy;

   wire fly_nxt = fly_evt || (fly_r && !(wr_sum && hwdata[`SDIS_SUM_FLY]));

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   logic [31:0] rd_val;
   always_comb
   begin
      rd_val = 32'h0000_0000;
      case (a_sel)
         SDIS_R_SUM:
         begin
            rd_val[`SDIS_SUM_DIP] = dma_pend;
            rd_val[`SDIS_SUM_SIP] = scsi_pend;
            rd_val[`SDIS_SUM_FLY] = fly_r;
         end
         SDIS_R_SLO: rd_val[7:0] = s_l1[7:0];
         SDIS_R_SHI: rd_val[7:0] = s_l1[15:8];
         SDIS_R_DST:
         begin
            rd_val[SDIS_DW-1:0] = d_l1;
            rd_val[`SDIS_DMA_IRQ_STATUS_FIFO_EMPTY] = dma_fifo_empty;
         end
         SDIS_R_ELO: rd_val[7:0] = s_en_r[7:0];
         SDIS_R_EHI: rd_val[7:0] = s_en_r[15:8];
         SDIS_R_DEN: rd_val[SDIS_DW-1:0] = d_en_r;
         SDIS_R_CTRL: rd_val[`SDIS_CTRL_PINMASK] = pin_mask_r;
         SDIS_R_MODE: rd_val[`SDIS_MODE_TARGET] = target_r;
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // Sequential state
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_pend_r <= 1'b0;
         wr_sel_r <= SDIS_R_NONE;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end
      else if (ce)
      begin
         wr_pend_r <= wr_take;
         wr_sel_r <= wr_take ? a_sel : SDIS_R_NONE;
      end
   end

   // Read data holds until the next read is taken
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hrdata_r <= 32'h0000_0000;
      end
      else if (ce)
      begin
         if (rd_take)
         begin
            hrdata_r <= rd_val;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_en_r <= `SDIS_RST_SEN;
         d_en_r <= `SDIS_RST_DEN;
      end
      else if (ce)
      begin
         if (wr_elo)
         begin
            s_en_r[7:0] <= hwdata[7:0];
         end
         if (wr_ehi)
         begin
            s_en_r[15:8] <= hwdata[7:0];
         end
         if (wr_den)
         begin
            d_en_r <= hwdata[SDIS_DW-1:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_mask_r <= `SDIS_RST_CTRL;
         target_r <= `SDIS_RST_MODE;
      end
      else if (ce)
      begin
         if (wr_ctl)
         begin
            pin_mask_r <= hwdata[`SDIS_CTRL_PINMASK];
         end
         if (wr_mod)
         begin
            target_r <= hwdata[`SDIS_MODE_TARGET];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fly_r <= 1'b0;
         s_hold_r <= '0;
      end
      else if (ce)
      begin
         fly_r <= fly_nxt;
         s_hold_r <= s_hold_nxt;
      end
   end

   // Pin and gap counter move together so the gap is exact
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gap_r <= 2'h0;
         irq_latched_r <= 1'b0;
         irq_req_n_r <= 1'b1;
      end
      else if (ce)
      begin
         gap_r <= gap_nxt;
         irq_latched_r <= irq_latched_nxt;
         irq_req_n_r <= !irq_on;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign hreadyout = hreadyout_r;
   assign hrdata = hrdata_r;
   assign hresp = hresp_r;
   assign irq_req_n = irq_req_n_r;
endmodule
`default_nettype wire

// ---- tb/sdis_irq_stack_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sdis_defs.svh"
module sdis_irq_stack_monitor
   import sdis_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic [SDIS_SW-1:0] scsi_evt,
   input wire logic [SDIS_DW-1:0] dma_evt,
   input wire logic fly_evt,
   input wire logic dma_fifo_empty,
   input wire sdis_eng_in_t eng_in,
   input wire sdis_eng_out_t eng_out,
   input wire logic irq_req_n
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
   // No new event for two edges, so a late low can only be the stack gap
   wire logic quiet = (scsi_evt == '0) && (dma_evt == '0) && !fly_evt;
   AST_READY_HIGH: assert property (hreadyout) else $error("wait state inserted");
   AST_RESP_OKAY: assert property (!hresp) else $error("error response seen");
   AST_GAP_THREE: assert property ($rose(irq_req_n) && quiet ##1 quiet |-> irq_req_n ##1 irq_req_n)
      else $error("request pin gap shorter than three cycles");
   AST_FIFO_FLAG: assert property (rd_take && haddr[7:0] == `SDIS_OFF_DMA_IRQ_STATUS |=>
      hrdata[7] == $past(dma_fifo_empty)) else $error("fifo empty flag wrong");
   AST_UNMAPPED_ZERO: assert property (rd_take && haddr[7:2] > 6'h08 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   AST_SLO_WIDTH: assert property (rd_take && haddr[7:0] == `SDIS_OFF_SSTAT_LO |=> hrdata[31:8] == 24'h0)
      else $error("status upper bits not zero");
   AST_DMA_FATAL: assert property (dma_evt != '0 |=> eng_out.stop_req)
      else $error("dma condition did not stop engine");
   AST_SCSI_FATAL: assert property (scsi_evt[0] && dma_fifo_empty |=> eng_out.stop_req)
      else $error("fatal condition did not stop engine");
   AST_HALT_CLEAN: assert property ($rose(eng_out.halted) |->
      $past(!eng_in.hs_busy && !eng_in.offset_busy && !eng_in.xfer_ctl_busy)) else $error("halt while busy");
   AST_FETCH_DONE: assert property ($rose(eng_out.halted) |-> $past(!eng_in.fetch_busy || eng_in.bus_fault))
      else $error("halt during fetch");
   AST_DRAIN_DONE: assert property ($rose(eng_out.halted) |->
      $past(!eng_out.drain_req || dma_fifo_empty)) else $error("halt before fifo drained");
   AST_JUMP_TARGET: assert property ($rose(eng_out.halted) |->
      eng_out.load_target == $past(eng_in.phase_jump)) else $error("jump target not loaded at halt");
endmodule
bind sdis_irq_stack sdis_irq_stack_monitor mon (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .scsi_evt(scsi_evt), .dma_evt(dma_evt), .fly_evt(fly_evt), .dma_fifo_empty(dma_fifo_empty),
   .eng_in(eng_in), .eng_out(eng_out), .irq_req_n(irq_req_n));
`default_nettype wire

// ---- tb/sdis_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sdis_defs.svh"
module sdis_host_model (
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial
   begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // ----------------------------------------
   // Single word transfer
   // ----------------------------------------
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Dma side first: its fault may change how the scsi side is handled
   task automatic service(output logic [31:0] d, output logic [31:0] s);
      xfer(`SDIS_OFF_DMA_IRQ_STATUS, 1'b0, 32'h0, d);
      repeat (12) @(posedge clk);
      xfer(`SDIS_OFF_SSTAT_LO, 1'b0, 32'h0, s);
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_sdis_irq_stack.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sdis_defs.svh"
module tb_sdis_irq_stack
   import sdis_pkg::*;
;
   logic clk, rst_n, ce, fly_evt, dma_fifo_empty, hsel, hwrite, hreadyout, hresp, irq_req_n;
   logic [31:0] haddr, hwdata, hrdata, d, s;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [SDIS_SW-1:0] scsi_evt;
   logic [SDIS_DW-1:0] dma_evt;
   sdis_eng_in_t eng_in;
   sdis_eng_out_t eng_out;
   int num_errors = 0;
   int n_compared = 0;
   sdis_irq_stack uut (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .scsi_evt(scsi_evt), .dma_evt(dma_evt), .fly_evt(fly_evt),
      .dma_fifo_empty(dma_fifo_empty), .eng_in(eng_in), .eng_out(eng_out), .irq_req_n(irq_req_n));
   sdis_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic report_and_stop();
      if (num_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      host.xfer(a, 1'b0, 32'h0, v);
      chk(v, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] u;
      host.xfer(a, 1'b1, v, u);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input logic [SDIS_SW-1:0] sv, input logic [SDIS_DW-1:0] dv, input logic fv);
      @(posedge clk);
      scsi_evt <= sv;
      dma_evt <= dv;
      fly_evt <= fv;
      @(posedge clk);
      scsi_evt <= '0;
      dma_evt <= '0;
      fly_evt <= 1'b0;
   endtask
   task automatic resume();
      @(posedge clk);
      eng_in.resume <= 1'b1;
      @(posedge clk);
      eng_in.resume <= 1'b0;
   endtask
   function automatic logic [31:0] bit1(input logic b);
      return {31'h0, b};
   endfunction
   initial
   begin
      #20000;
      num_errors++;
      report_and_stop();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      rst_n = 1'b0;
      ce = 1'b1;
      scsi_evt = '0;
      dma_evt = '0;
      fly_evt = 1'b0;
      dma_fifo_empty = 1'b1;
      eng_in = '0;
      cyc(3);
      rst_n <= 1'b1;
      rdc(`SDIS_OFF_SUMMARY, 32'h0);
      rdc(8'h3C, 32'h0);
      pulse(16'h0010, 7'h00, 1'b0);
      cyc(2);
      rdc(`SDIS_OFF_SUMMARY, 32'h0);
      chk(bit1(irq_req_n), 32'h1);
      chk(bit1(eng_out.stop_req), 32'h0);
      wr(`SDIS_OFF_SEN_LO, 32'h1);
      pulse(16'h0001, 7'h00, 1'b0);
      cyc(3);
      chk(bit1(irq_req_n), 32'h0);
      rdc(`SDIS_OFF_SSTAT_LO, 32'h11);
      rdc(`SDIS_OFF_SUMMARY, 32'h0);
      eng_in.fetch_busy <= 1'b1;
      resume();
      pulse(16'h0000, 7'h01, 1'b0);
      cyc(3);
      chk(bit1(eng_out.stop_req), 32'h1);
      chk(bit1(eng_out.halted), 32'h0);
      chk(bit1(irq_req_n), 32'h1);
      rdc(`SDIS_OFF_SUMMARY, 32'h1);
      eng_in.fetch_busy <= 1'b0;
      cyc(3);
      chk(bit1(eng_out.halted), 32'h1);
      rdc(`SDIS_OFF_DMA_IRQ_STATUS, 32'h81);
      rdc(`SDIS_OFF_DMA_IRQ_STATUS, 32'h80);
      resume();
      wr(`SDIS_OFF_SEN_LO, 32'h7);
      pulse(16'h0003, 7'h00, 1'b0);
      cyc(3);
      pulse(16'h0004, 7'h00, 1'b0);
      pulse(16'h0008, 7'h00, 1'b0);
      rdc(`SDIS_OFF_SSTAT_LO, 32'h3);
      cyc(2);
      chk(bit1(irq_req_n), 32'h1);
      cyc(6);
      chk(bit1(irq_req_n), 32'h0);
      rdc(`SDIS_OFF_SUMMARY, 32'h2);
      rdc(`SDIS_OFF_SSTAT_LO, 32'hC);
      resume();
      dma_fifo_empty <= 1'b0;
      pulse(16'h0001, 7'h00, 1'b0);
      cyc(3);
      rdc(`SDIS_OFF_SUMMARY, 32'h0);
      dma_fifo_empty <= 1'b1;
      cyc(3);
      rdc(`SDIS_OFF_SUMMARY, 32'h2);
      rdc(`SDIS_OFF_SSTAT_LO, 32'h1);
      resume();
      wr(`SDIS_OFF_DEN, 32'h1);
      wr(`SDIS_OFF_CTRL, 32'h2);
      pulse(16'h0000, 7'h01, 1'b0);
      cyc(4);
      chk(bit1(irq_req_n), 32'h1);
      wr(`SDIS_OFF_CTRL, 32'h0);
      cyc(2);
      chk(bit1(irq_req_n), 32'h0);
      rdc(`SDIS_OFF_DMA_IRQ_STATUS, 32'h81);
      resume();
      pulse(16'h0001, 7'h01, 1'b0);
      cyc(3);
      rdc(`SDIS_OFF_SUMMARY, 32'h3);
      host.service(d, s);
      chk(d, 32'h81);
      chk(s, 32'h1);
      resume();
      pulse(16'h0000, 7'h00, 1'b1);
      cyc(3);
      rdc(`SDIS_OFF_SUMMARY, 32'h4);
      rdc(`SDIS_OFF_SUMMARY, 32'h4);
      wr(`SDIS_OFF_SUMMARY, 32'h4);
      rdc(`SDIS_OFF_SUMMARY, 32'h0);
      cyc(2);
      chk(bit1(irq_req_n), 32'h1);
      wr(`SDIS_OFF_MODE, 32'h1);
      pulse(16'h0180, 7'h00, 1'b0);
      cyc(2);
      chk(bit1(eng_out.stop_req), 32'h0);
      rdc(`SDIS_OFF_SUMMARY, 32'h0);
      rdc(`SDIS_OFF_SSTAT_LO, 32'h80);
      rdc(`SDIS_OFF_SSTAT_HI, 32'h1);
      rdc(`SDIS_OFF_SSTAT_HI, 32'h0);
      // Memory write, handshake, offset and transfer busy, phase jump
      eng_in <= 9'h05E;
      pulse(16'h0001, 7'h00, 1'b0);
      cyc(3);
      chk(bit1(eng_out.drain_req), 32'h1);
      chk(bit1(eng_out.halted), 32'h0);
      // Link idle, bus cycle busy, fifo refilled: drain must still wait
      eng_in <= 9'h062;
      dma_fifo_empty <= 1'b0;
      cyc(3);
      chk(bit1(eng_out.halted), 32'h0);
      dma_fifo_empty <= 1'b1;
      cyc(3);
      chk(bit1(eng_out.halted), 32'h1);
      chk(bit1(eng_out.drain_req), 32'h0);
      rdc(`SDIS_OFF_SSTAT_LO, 32'h1);
      report_and_stop();
   end
endmodule
`default_nettype wire
